// *** src/sar_seq_pkg.sv ***
// Shared constants for the conversion link: code layout, timing and counts.
// Assumes a single 100 MHz system clock on both ends of the link.
package sar_seq_pkg;

  // Result width, conversion length and calibration length
  localparam int RES_BITS = 16;
  localparam int CONV_CLOCKS = 17;
  localparam int CAL_CLOCKS = 85530;

  // Output codes
  localparam logic [15:0] CODE_MAX = 16'h7FFF;
  localparam logic [15:0] CODE_MIN = 16'h8000;
  localparam logic [15:0] MSB_FLIP = 16'h8000;

  // System clock
  localparam int CLK_PERIOD_NS = 10;

  // Link timing in ns, except the conversion limit in us
  localparam int APERTURE_NS = 20;
  localparam int STROBE_TO_BUSY_NS = 40;
  localparam int STROBE_TO_CLOCK_NS = 200;
  localparam int MIN_ACQUIRE_NS = 2000;
  localparam int MIN_STROBE_LOW_NS = 100;
  localparam int CAL_HIGH_NS = 100;
  localparam int CLOCK_PERIOD_NS = 160;
  localparam int MAX_CONVERSION_US = 1000;

  // Least time in ns to whole clock cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  // Derived cycle counts
  localparam int APERTURE_CYC = ns_to_cyc(APERTURE_NS);
  localparam int BUSY_CYC = ns_to_cyc(STROBE_TO_BUSY_NS);
  localparam int SC_CYC = ns_to_cyc(STROBE_TO_CLOCK_NS);
  localparam int ACQ_CYC = ns_to_cyc(MIN_ACQUIRE_NS);
  localparam int SL_CYC = ns_to_cyc(MIN_STROBE_LOW_NS);
  localparam int CAL_HIGH_CYC = ns_to_cyc(CAL_HIGH_NS);
  localparam int LINK_HALF_CYC = ns_to_cyc(CLOCK_PERIOD_NS / 2);
  localparam int SYNC_MARGIN = 4;
  localparam int LOW_WAIT_CYC = ((SC_CYC > SL_CYC) ? SC_CYC : SL_CYC) + SYNC_MARGIN;

endpackage : sar_seq_pkg

// *** src/sar_link_if.sv ***
// Pin bundle between the controller and the converter's sequencer.
// Assumes both ends run on their own copy of the 100 MHz system clock.
`timescale 1ns/1ps
interface sar_link_if;
  logic acq_strobe;
  logic conv_clk;
  logic cal_req;
  logic busy;
  logic [sar_seq_pkg::RES_BITS-1:0] result;

  // Converter end
  modport dev (
    input acq_strobe,
    input conv_clk,
    input cal_req,
    output busy,
    output result
  );

  // Controller end
  modport host (
    output acq_strobe,
    output conv_clk,
    output cal_req,
    input busy,
    input result
  );
endinterface : sar_link_if

// *** src/sar_conv_device.sv ***
// Converter end: acquisition, commit, busy flag, 17-clock search, calibration.
// Assumes all link pins are asynchronous to MCLK and the controller makes the
// conversion clock; ANALOG_IN is a digital stand-in on the MCLK domain.
`timescale 1ns/1ps
module sar_conv_device #(
  parameter int AW = 18,
  parameter int CAL_CLOCKS = sar_seq_pkg::CAL_CLOCKS
) (
  // System
  input wire logic MCLK,
  input wire logic RST,
  // Link to the controller
  sar_link_if.dev LINK,
  // Input value and status
  input wire logic signed [AW-1:0] ANALOG_IN,
  output logic CALIBRATED,
  output logic SAMPLE_TAKEN
);

  localparam int NB = sar_seq_pkg::RES_BITS;
  localparam int CW = $clog2(CAL_CLOCKS + 1);
  localparam logic [7:0] APER_LIM = 8'(sar_seq_pkg::APERTURE_CYC);
  localparam logic [7:0] BUSY_LIM = 8'(sar_seq_pkg::BUSY_CYC);
  localparam logic [7:0] SC_LIM = 8'(sar_seq_pkg::SC_CYC);
  localparam logic [4:0] LAST_EDGE = 5'(sar_seq_pkg::CONV_CLOCKS - 1);
  localparam logic [4:0] TOP_BIT = 5'(NB - 1);
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CLOCKS - 1);

  // Elaboration checks
  if (AW <= NB) begin : g_bad_aw
    $error("ANALOG_IN must be wider than the result");
  end
  if (CAL_CLOCKS < 1) begin : g_bad_cal
    $error("CAL_CLOCKS must be at least one");
  end
  if (sar_seq_pkg::SC_CYC > 255 || sar_seq_pkg::SC_CYC <= sar_seq_pkg::APERTURE_CYC ||
      sar_seq_pkg::SC_CYC <= sar_seq_pkg::BUSY_CYC) begin : g_bad_timing
    $error("strobe-to-clock delay must exceed aperture and busy delays");
  end

  typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_CONV} dev_state_t;

  // Clamp to the end codes, then pass the value in twos complement
  function automatic logic [NB-1:0] clamp_code(input logic signed [AW-1:0] v);
    logic signed [AW-1:0] hi;
    logic signed [AW-1:0] lo;
    hi = $signed({{(AW-NB){1'b0}}, sar_seq_pkg::CODE_MAX});
    lo = $signed({{(AW-NB){1'b1}}, sar_seq_pkg::CODE_MIN});
    if (v > hi) begin
      return sar_seq_pkg::CODE_MAX;
    end else if (v < lo) begin
      return sar_seq_pkg::CODE_MIN;
    end
    return v[NB-1:0];
  endfunction : clamp_code

  // One search step: keep the trial bit if the held value reaches it
  function automatic logic [NB-1:0] sar_step(input logic [NB-1:0] acc,
                                              input logic [NB-1:0] tgt,
                                              input logic [4:0] idx);
    logic [NB-1:0] trial;
    trial = acc | (NB'(1) << idx);
    return (tgt >= trial) ? trial : acc;
  endfunction : sar_step

  logic rst_any;
  logic [1:0] rel_ff;
  logic core_rst;
  logic strb_s1_ff;
  logic strb_s2_ff;
  logic strb_d_ff;
  logic clk_s1_ff;
  logic clk_s2_ff;
  logic clk_d_ff;
  logic strb_fall;
  logic clk_rise;
  logic since_ok;
  logic edge_ok;
  logic tail_eat;
  logic cal_done;
  dev_state_t state_ff;
  logic [CW-1:0] cal_cnt_ff;
  logic [7:0] since_ff;
  logic [4:0] edge_cnt_ff;
  logic cal_tail_ff;
  logic [NB-1:0] target_ff;
  logic [NB-1:0] sar_ff;
  logic busy_ff;
  logic [NB-1:0] result_ff;

  // Calibration request acts as an asynchronous reset; release is synchronous
  assign rst_any = RST | LINK.cal_req;

  // Reset release synchroniser, so no flip-flop leaves reset mid-edge
  always_ff @(posedge MCLK or posedge rst_any) begin
    if (rst_any) begin
      rel_ff <= 2'h3;
    end else begin
      rel_ff <= {rel_ff[0], 1'b0};
    end
  end
  assign core_rst = rel_ff[1];

  // Two-stage synchronisers for strobe and conversion clock, plus edge history
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      strb_s1_ff <= 1'b0;
      strb_s2_ff <= 1'b0;
      strb_d_ff <= 1'b0;
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_d_ff <= 1'b0;
    end else begin
      strb_s1_ff <= LINK.acq_strobe;
      strb_s2_ff <= strb_s1_ff;
      strb_d_ff <= strb_s2_ff;
      clk_s1_ff <= LINK.conv_clk;
      clk_s2_ff <= clk_s1_ff;
      clk_d_ff <= clk_s2_ff;
    end
  end

  // Edge detection on the synchronised copies only
  assign strb_fall = strb_d_ff & ~strb_s2_ff;
  assign clk_rise = clk_s2_ff & ~clk_d_ff;
  assign since_ok = (since_ff >= SC_LIM);
  // A counted edge needs the delay elapsed and any calibration tail consumed
  assign edge_ok = (state_ff == ST_CONV) & clk_rise & since_ok & ~cal_tail_ff;
  assign tail_eat = clk_rise & cal_tail_ff &
                    ((state_ff == ST_IDLE) | ((state_ff == ST_CONV) & since_ok));
  assign cal_done = (state_ff == ST_CAL) & clk_rise & (cal_cnt_ff == CAL_LAST);

  // Sequencer: calibrate after reset, then wait for a strobe fall, then convert
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      state_ff <= ST_CAL;
      edge_cnt_ff <= 5'h00;
    end else begin
      case (state_ff)
        ST_CAL: begin
          if (cal_done) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // A strobe held high across the busy fall makes its own fall later
          if (strb_fall) begin
            state_ff <= ST_CONV;
            edge_cnt_ff <= 5'h00;
          end
        end
        ST_CONV: begin
          // Strobe is not looked at here until the conversion ends
          if (edge_ok) begin
            edge_cnt_ff <= edge_cnt_ff + 5'h01;
            if (edge_cnt_ff == LAST_EDGE) begin
              state_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= ST_CAL;
        end
      endcase
    end
  end

  // Calibration clock count, taken on conversion clock rising edges
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      cal_cnt_ff <= '0;
    end else if ((state_ff == ST_CAL) && clk_rise) begin
      cal_cnt_ff <= cal_cnt_ff + CW'(1);
    end
  end

  // Extra clock owed after calibration; if missed, the first conversion eats it
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      cal_tail_ff <= 1'b0;
    end else if (cal_done) begin
      cal_tail_ff <= 1'b1;
    end else if (tail_eat) begin
      cal_tail_ff <= 1'b0;
    end
  end

  // Cycles since the committing strobe fall, saturating at the clock delay
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      since_ff <= 8'h00;
    end else if ((state_ff == ST_IDLE) && strb_fall) begin
      since_ff <= 8'h00;
    end else if ((state_ff == ST_CONV) && !since_ok) begin
      since_ff <= since_ff + 8'h01;
    end
  end

  // Hold the input one aperture delay after the fall, offset binary inside
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      target_ff <= '0;
    end else if ((state_ff == ST_CONV) && (since_ff == APER_LIM)) begin
      target_ff <= clamp_code(ANALOG_IN) ^ sar_seq_pkg::MSB_FLIP;
    end
  end

  // Successive approximation: edges 1..16 decide bits from the top down
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      sar_ff <= '0;
    end else if ((state_ff == ST_IDLE) && strb_fall) begin
      sar_ff <= '0;
    end else if (edge_ok && (edge_cnt_ff != LAST_EDGE)) begin
      sar_ff <= sar_step(sar_ff, target_ff, TOP_BIT - edge_cnt_ff);
    end
  end

  // Busy: high through calibration, rises after the fall, drops on edge 17
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      busy_ff <= 1'b1;
    end else if (cal_done) begin
      busy_ff <= 1'b0;
    end else if ((state_ff == ST_CONV) && (since_ff == BUSY_LIM)) begin
      busy_ff <= 1'b1;
    end else if (edge_ok && (edge_cnt_ff == LAST_EDGE)) begin
      busy_ff <= 1'b0;
    end
  end

  // Result register: changes only on the final edge, same cycle as busy drop
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      result_ff <= '0;
    end else if (edge_ok && (edge_cnt_ff == LAST_EDGE)) begin
      result_ff <= sar_ff ^ sar_seq_pkg::MSB_FLIP;
    end
  end

  // Status toward local logic
  always_ff @(posedge MCLK or posedge core_rst) begin
    if (core_rst) begin
      CALIBRATED <= 1'b0;
      SAMPLE_TAKEN <= 1'b0;
    end else begin
      if (cal_done) begin
        CALIBRATED <= 1'b1;
      end
      SAMPLE_TAKEN <= (state_ff == ST_CONV) && (since_ff == APER_LIM);
    end
  end

  // Link outputs straight from their registers
  assign LINK.busy = busy_ff;
  assign LINK.result = result_ff;

endmodule : sar_conv_device

// *** src/sar_conv_host.sv ***
// Controller end: strobe timing, gated divided clock, calibration, result buffer.
// Assumes busy and result arrive asynchronously; RES_READY is on MCLK.
`timescale 1ns/1ps
module sar_conv_host #(
  parameter int CLK_HALF = sar_seq_pkg::LINK_HALF_CYC,
  parameter int DEPTH = 2
) (
  // System
  input wire logic MCLK,
  input wire logic RST,
  // Link to the converter
  sar_link_if.host LINK,
  // Commands
  input wire logic RUN,
  input wire logic CAL_START,
  // Result stream
  output logic [sar_seq_pkg::RES_BITS-1:0] RES_DATA,
  output logic RES_VALID,
  input wire logic RES_READY
);

  localparam int NB = sar_seq_pkg::RES_BITS;
  localparam int KW = $clog2(DEPTH + 1);
  localparam logic [7:0] HALF_LAST = 8'(CLK_HALF - 1);
  localparam logic [4:0] LAST_PULSE = 5'(sar_seq_pkg::CONV_CLOCKS - 1);
  localparam logic [15:0] ACQ_LD = 16'(sar_seq_pkg::ACQ_CYC - 1);
  localparam logic [15:0] LOW_LD = 16'(sar_seq_pkg::LOW_WAIT_CYC - 1);
  localparam logic [15:0] CALH_LD = 16'(sar_seq_pkg::CAL_HIGH_CYC - 1);

  // Elaboration checks
  // Each clock level must last three cycles to pass the converter's synchroniser
  if (CLK_HALF < 3 || CLK_HALF > 256) begin : g_bad_half
    $error("CLK_HALF out of range");
  end
  if (DEPTH < 2) begin : g_bad_depth
    $error("DEPTH must be at least two");
  end

  typedef enum logic [2:0] {
    H_CALHI, H_CALRUN, H_CALTAIL, H_IDLE, H_ACQ, H_LOW, H_CLK, H_WAIT
  } host_state_t;

  host_state_t state_ff;
  logic [15:0] tmr_ff;
  logic [4:0] pulse_ff;
  logic [7:0] ph_ff;
  logic cclk_ff;
  logic strobe_ff;
  logic cal_ff;
  logic busy_s1_ff;
  logic busy_s2_ff;
  logic [NB-1:0] data_s1_ff;
  logic [NB-1:0] data_s2_ff;
  logic [NB-1:0] mem_ff [DEPTH];
  logic [KW-1:0] cnt_ff;
  logic run_clk;
  logic pulse_end;
  logic push;
  logic pop;
  logic room;
  logic [KW-1:0] wr_idx;
  logic [KW-1:0] nxt_cnt;

  // Synchronise busy and result before any use
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      busy_s1_ff <= 1'b1;
      busy_s2_ff <= 1'b1;
      data_s1_ff <= '0;
      data_s2_ff <= '0;
    end else begin
      busy_s1_ff <= LINK.busy;
      busy_s2_ff <= busy_s1_ff;
      data_s1_ff <= LINK.result;
      data_s2_ff <= data_s1_ff;
    end
  end

  // Clock runs only while clocking; held low otherwise, 50 percent duty
  assign run_clk = (state_ff == H_CALRUN) || (state_ff == H_CALTAIL) || (state_ff == H_CLK);
  assign pulse_end = run_clk && (ph_ff == HALF_LAST) && cclk_ff;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ph_ff <= 8'h00;
      cclk_ff <= 1'b0;
    end else if (!run_clk) begin
      ph_ff <= 8'h00;
      cclk_ff <= 1'b0;
    end else if (ph_ff == HALF_LAST) begin
      ph_ff <= 8'h00;
      cclk_ff <= ~cclk_ff;
    end else begin
      ph_ff <= ph_ff + 8'h01;
    end
  end

  // Sequencer: calibrate after reset, then one conversion per free buffer slot
  assign room = (cnt_ff < KW'(DEPTH));
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_ff <= H_CALHI;
      tmr_ff <= CALH_LD;
      pulse_ff <= 5'h00;
      strobe_ff <= 1'b0;
      cal_ff <= 1'b1;
    end else begin
      case (state_ff)
        H_CALHI: begin
          if (tmr_ff == 16'h0000) begin
            cal_ff <= 1'b0;
            state_ff <= H_CALRUN;
          end else begin
            tmr_ff <= tmr_ff - 16'h0001;
          end
        end
        H_CALRUN: begin
          // Let the pulse that ended calibration finish; the owed clock must rise later
          if (!busy_s2_ff && pulse_end) begin
            state_ff <= H_CALTAIL;
          end
        end
        H_CALTAIL: begin
          if (pulse_end) begin
            state_ff <= H_IDLE;
          end
        end
        H_IDLE: begin
          if (CAL_START) begin
            cal_ff <= 1'b1;
            tmr_ff <= CALH_LD;
            state_ff <= H_CALHI;
          end else if (RUN && room && !busy_s2_ff) begin
            strobe_ff <= 1'b1;
            tmr_ff <= ACQ_LD;
            state_ff <= H_ACQ;
          end
        end
        H_ACQ: begin
          if (tmr_ff == 16'h0000) begin
            strobe_ff <= 1'b0;
            tmr_ff <= LOW_LD;
            state_ff <= H_LOW;
          end else begin
            tmr_ff <= tmr_ff - 16'h0001;
          end
        end
        H_LOW: begin
          if (tmr_ff == 16'h0000) begin
            pulse_ff <= 5'h00;
            state_ff <= H_CLK;
          end else begin
            tmr_ff <= tmr_ff - 16'h0001;
          end
        end
        H_CLK: begin
          if (pulse_end) begin
            pulse_ff <= pulse_ff + 5'h01;
            if (pulse_ff == LAST_PULSE) begin
              state_ff <= H_WAIT;
            end
          end
        end
        H_WAIT: begin
          if (!busy_s2_ff) begin
            state_ff <= H_IDLE;
          end
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  // Result buffer: shift register, head at slot 0
  assign push = (state_ff == H_WAIT) && !busy_s2_ff;
  assign pop = RES_VALID && RES_READY;
  assign wr_idx = cnt_ff - KW'(pop);
  assign nxt_cnt = cnt_ff + KW'(push) - KW'(pop);
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
        mem_ff[i] <= '0;
      end else if (push && (wr_idx == KW'(i))) begin
        mem_ff[i] <= data_s2_ff;
      end else if (pop) begin
        if (i < DEPTH - 1) begin
          mem_ff[i] <= mem_ff[(i < DEPTH - 1) ? i + 1 : i];
        end
      end
    end
  end

  // Occupancy and valid flag
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt_ff <= '0;
      RES_VALID <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      RES_VALID <= (nxt_cnt != '0);
    end
  end

  // Outputs from registers
  assign RES_DATA = mem_ff[0];
  assign LINK.acq_strobe = strobe_ff;
  assign LINK.conv_clk = cclk_ff;
  assign LINK.cal_req = cal_ff;

endmodule : sar_conv_host

// *** testbench/sar_link_assertions.sv ***
// Checker on the link pins between the controller end and the converter end.
// Assumes every link signal is sampled on MCLK, with RST async and active high.
`timescale 1ns/1ps
module sar_link_assertions (
  // System
  input logic MCLK,
  input logic RST,
  // Link pins
  input logic acq_strobe,
  input logic conv_clk,
  input logic cal_req,
  input logic busy,
  input logic [sar_seq_pkg::RES_BITS-1:0] result
);
  logic strobe_q_ff;
  logic clk_q_ff;
  logic in_conv_ff;
  logic [4:0] edge_cnt_ff;
  logic [7:0] since_ff;
  logic [8:0] hi_cnt_ff;
  logic strobe_fall;
  logic clk_rise;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  // Edges of the strobe and of the link clock
  assign strobe_fall = strobe_q_ff & ~acq_strobe;
  assign clk_rise = ~clk_q_ff & conv_clk;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      strobe_q_ff <= 1'b0;
      clk_q_ff <= 1'b0;
    end else begin
      strobe_q_ff <= acq_strobe;
      clk_q_ff <= conv_clk;
    end
  end

  // Conversion window, from a committed strobe fall to the 17th edge
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) in_conv_ff <= 1'b0;
    else if (cal_req) in_conv_ff <= 1'b0;
    else if (strobe_fall && !busy) in_conv_ff <= 1'b1;
    else if (!busy && edge_cnt_ff == 5'h11) in_conv_ff <= 1'b0;
  end

  // Clock rises and cycles counted from the committed strobe fall
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      edge_cnt_ff <= 5'h00;
      since_ff <= 8'h00;
    end else if (strobe_fall && !busy) begin
      edge_cnt_ff <= 5'h00;
      since_ff <= 8'h00;
    end else begin
      if (clk_rise && edge_cnt_ff != 5'h1F) edge_cnt_ff <= edge_cnt_ff + 5'h01;
      if (since_ff != 8'hFF) since_ff <= since_ff + 8'h01;
    end
  end

  // Length of the present strobe high phase
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) hi_cnt_ff <= 9'h000;
    else if (!acq_strobe) hi_cnt_ff <= 9'h000;
    else if (hi_cnt_ff != 9'h1FF) hi_cnt_ff <= hi_cnt_ff + 9'h001;
  end

  a_busy_rise:
  assert property (strobe_fall && !busy && !cal_req |-> !busy[*3] ##[1:8] busy)
    else $error("busy did not rise after the committed strobe fall");
  a_busy_held:
  assert property (in_conv_ff && edge_cnt_ff != 5'h00 && edge_cnt_ff < 5'h11 |-> busy)
    else $error("busy low in mid conversion");
  a_conv_count:
  assert property ($fell(busy) && in_conv_ff |-> edge_cnt_ff == 5'h11)
    else $error("busy fell after a clock count other than 17");
  a_busy_fall_time:
  assert property (in_conv_ff && edge_cnt_ff == 5'h10 && clk_rise |-> ##[1:6] $fell(busy))
    else $error("busy did not fall soon after the 17th clock");
  a_result_hold:
  assert property (@(posedge MCLK) disable iff (RST || cal_req) $changed(result) |-> $fell(busy))
    else $error("result changed apart from a busy fall");
  a_cal_busy:
  assert property (cal_req |-> busy)
    else $error("busy low while calibration is requested");
  a_clk_late:
  assert property (clk_rise && in_conv_ff |-> since_ff >= sar_seq_pkg::SC_CYC)
    else $error("link clock rose too soon after the strobe fall");
  a_acq_no_clk:
  assert property (acq_strobe |-> $stable(conv_clk))
    else $error("link clock moved during acquisition");
  a_clk_low_half:
  assert property ($fell(conv_clk) |-> !conv_clk[*8])
    else $error("link clock low phase too short");
  a_strobe_times:
  assert property (strobe_fall |-> hi_cnt_ff >= sar_seq_pkg::ACQ_CYC ##0 !acq_strobe[*8])
    else $error("strobe high or low phase too short");
endmodule : sar_link_assertions

// *** testbench/tb.sv ***
// Self-checking bench: controller and converter ends joined by the link.
// Assumes the checker watches the link; the bench drives commands and reads results.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  localparam int NV = 7;
  logic mclk;
  logic rst;
  logic run;
  logic cal_start;
  logic res_ready;
  logic signed [17:0] analog_in = 18'h00000;
  logic calibrated;
  logic sample_taken;
  logic [sar_seq_pkg::RES_BITS-1:0] res_data;
  logic res_valid;
  logic [15:0] exp_q[$];
  logic signed [17:0] vals[NV] = '{18'h00000, 18'h07FFF, 18'h08000, 18'h1FFFF,
    18'h3FFFF, 18'h38000, 18'h37FFF};
  int n_fail;
  int total_checks;
  int n_samp = 0;
  int i;

  sar_link_if link();
  sar_conv_device #(.CAL_CLOCKS(20)) i_sar_conv_device (.MCLK(mclk), .RST(rst), .LINK(link),
    .ANALOG_IN(analog_in), .CALIBRATED(calibrated), .SAMPLE_TAKEN(sample_taken));
  sar_conv_host i_sar_conv_host (.MCLK(mclk), .RST(rst), .LINK(link), .RUN(run),
    .CAL_START(cal_start), .RES_DATA(res_data), .RES_VALID(res_valid), .RES_READY(res_ready));
  sar_link_assertions i_sar_link_assertions (.MCLK(mclk), .RST(rst),
    .acq_strobe(link.acq_strobe), .conv_clk(link.conv_clk), .cal_req(link.cal_req),
    .busy(link.busy), .result(link.result));

  // System clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Expected code: twos complement, clamped at both ends
  function automatic logic [15:0] clamp(input logic signed [17:0] v);
    if (v > 18'sh07FFF) return sar_seq_pkg::CODE_MAX;
    if (v < -18'sh08000) return sar_seq_pkg::CODE_MIN;
    return v[15:0];
  endfunction : clamp

  // Record the expected code at each capture, then present the next input
  always @(posedge mclk) begin
    if (sample_taken === 1'b1) begin
      exp_q.push_back(clamp(analog_in));
      n_samp++;
      #1;
      analog_in = vals[n_samp % NV];
    end
  end

  // Verdict and end of run
  task automatic finish_test(input bit hung);
    if (hung) begin
      n_fail++;
      $display("Error wait_limit expected done seen hung");
    end
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Wait for a buffered word, hold off stall cycles, compare, then pop it
  task automatic read_result(input int stall);
    int k;
    logic [15:0] e;
    for (k = 0; k < 3000 && res_valid !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    if (res_valid !== 1'b1) finish_test(1'b1);
    repeat (stall) @(posedge mclk);
    #1;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hXXXX;
    `CHK("res_data", e, res_data)
    @(posedge mclk);
    #1;
    res_ready = 1'b1;
    @(posedge mclk);
    #1;
    res_ready = 1'b0;
  endtask : read_result

  // Wait for calibration to finish with busy low
  task automatic wait_cal();
    int k;
    for (k = 0; k < 5000 && !(calibrated === 1'b1 && link.busy === 1'b0); k++) begin
      @(posedge mclk);
      #1;
    end
    if (k == 5000) finish_test(1'b1);
  endtask : wait_cal

  // Main sequence
  initial begin
    rst = 1'b1;
    run = 1'b0;
    cal_start = 1'b0;
    res_ready = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    wait_cal();
    `CHK("calibrated", 1'b1, calibrated)
    // The controller must still give one clock after busy falls
    repeat (40) @(posedge mclk);
    #1;
    `CHK("cal_tail", 1'b0, i_sar_conv_device.cal_tail_ff)
    // Reader stalled: two words fill the buffer, then converting stops
    run = 1'b1;
    repeat (2500) @(posedge mclk);
    #1;
    `CHK("captures", 2, n_samp)
    `CHK("acq_strobe", 1'b0, link.acq_strobe)
    `CHK("result", clamp(vals[1]), link.result)
    // Drain with varied stalls while conversions continue behind
    for (i = 0; i < NV + 2; i++) read_result(i % 3);
    run = 1'b0;
    repeat (1200) @(posedge mclk);
    for (i = 0; i < 3 && res_valid === 1'b1; i++) read_result(0);
    `CHK("pending", 0, exp_q.size())
    // Recalibrate, then the first conversion must come out whole
    cal_start = 1'b1;
    @(posedge mclk);
    #1;
    cal_start = 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("cal_busy", 1'b1, link.busy)
    `CHK("calibrated", 1'b0, calibrated)
    wait_cal();
    run = 1'b1;
    read_result(0);
    run = 1'b0;
    finish_test(1'b0);
  end
endmodule : tb
